// [logic/esl_regs.svh]
`ifndef ESL_REGS_SVH
`define ESL_REGS_SVH
// ----------------------------------------
// status word bit positions (vector index)
// ----------------------------------------
// word bit 00 is the msb, so word bit k sits at index 15-k
`define ESL_B_SPEC 15
`define ESL_B_BADADR 14
`define ESL_B_PRIV 13
`define ESL_B_INVFN 11
`define ESL_B_STACK 9
`define ESL_B_PARITY 7
`define ESL_B_CTRL 5
`define ESL_B_IOCHK 4
`define ESL_B_SEQ 3
`define ESL_B_AIPL 2
`define ESL_B_PWR 0
`define ESL_PSW_USED 16'hEABD
`define ESL_PSW_RST 16'h0000
// ----------------------------------------
// level block layout and status bits
// ----------------------------------------
`define ESL_LSB_LAST 4'hA
`define ESL_LSB_IDX_LSR 4'h2
`define ESL_LSR_SUP 7
`define ESL_LSR_INPROC 6
`define ESL_LSR_SUM 4
`define ESL_LSR_RST 16'h0010
`define ESL_WORD_STEP 16'h0002
`endif

// [logic/esl_pkg.sv]
`default_nettype none
package esl_pkg;
  typedef logic [1:0] esl_lvl_t;
  typedef logic [15:0] esl_word_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01,
    ST_LOAD = 2'b10,
    ST_SWITCH = 2'b11
  } esl_st_t;
  typedef enum logic {
    LDR_IDLE = 1'b0,
    LDR_READ = 1'b1
  } esl_ldr_st_t;
endpackage : esl_pkg
`default_nettype wire

// [logic/esl_ldr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface esl_ldr_if;
  import esl_pkg::*;
  logic start;
  esl_word_t ea;
  logic busy;
  logic done;
  logic mem_req;
  esl_word_t mem_addr;
  logic mem_ack;
  esl_word_t mem_rdata;
  logic wr;
  logic [3:0] idx;
  esl_word_t data;
  modport ctl (output start, ea, mem_ack, mem_rdata,
               input busy, done, mem_req, mem_addr, wr, idx, data);
  modport ldr (input start, ea, mem_ack, mem_rdata,
               output busy, done, mem_req, mem_addr, wr, idx, data);
endinterface : esl_ldr_if
`default_nettype wire

// [logic/esl_opdecode.sv]
`timescale 1ns/1ps
`default_nettype none
module esl_opdecode (
  input wire logic [4:0] opcode_i, // operation code field
  input wire logic [4:0] func_i,   // function field, bit 4 used only for 0E and 0F
  input wire logic sup_i,          // supervisor state
  output logic illegal_o,          // illegal combination
  output logic reserved_o          // reserved combination
);
  // illegal combinations, all lead to program check
  wire op_0b = (opcode_i == 5'h0B);
  wire [3:0] f4 = func_i[3:0];
  wire ill_08 = (opcode_i == 5'h08) && (f4 != 4'h0) && (f4 != 4'h4) && !f4[3];
  wire ill_0b = op_0b && ((sup_i && (f4 == 4'h1 || f4 == 4'h9)) || f4 == 4'h5 || f4 == 4'h7);
  wire ill_0e = (opcode_i == 5'h0E) && func_i[4] && func_i[3] && (func_i[2:0] != 3'h1)
                && (func_i[2:0] != 3'h5);
  wire ill_0f = (opcode_i == 5'h0F) && ((func_i[4] && func_i[2]) || (func_i[4:3] == 2'b01)
                || (func_i[4] && func_i[1:0] == 2'b11 && !func_i[2]) || func_i == 5'h11);
  assign illegal_o = (opcode_i == 5'h07) || ill_08 || ill_0b || ill_0e || ill_0f
                     || (opcode_i == 5'h0C && func_i[2:0] == 3'h7)
                     || (opcode_i == 5'h16) || (opcode_i == 5'h1B)
                     || (opcode_i == 5'h1D && f4[3:2] == 2'b11);
  // reserved combinations go to the soft trap instead
  assign reserved_o = (opcode_i == 5'h04) || (op_0b && sup_i && f4[2:0] == 3'h3);
endmodule : esl_opdecode
`default_nettype wire

// [logic/esl_lsb_loader.sv]
`timescale 1ns/1ps
`default_nettype none
`include "esl_regs.svh"
module esl_lsb_loader (
  input wire logic core_clk_i, // core clock
  input wire logic srst_i,     // sync reset
  input wire logic ce_i,       // clock enable
  esl_ldr_if.ldr lb            // control and storage side
);
  import esl_pkg::*;
  esl_ldr_st_t st_r;
  logic [3:0] idx_r;
  esl_word_t addr_r;
  logic wr_r;
  logic done_r;
  esl_word_t data_r;
  wire last = (idx_r == `ESL_LSB_LAST);
  // reads the block one word per storage handshake
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= LDR_IDLE;
      idx_r <= 4'h0;
      addr_r <= 16'h0000;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      data_r <= 16'h0000;
    end else if (ce_i) begin
      wr_r <= 1'b0;
      done_r <= 1'b0;
      if (st_r == LDR_IDLE && lb.start) begin
        st_r <= LDR_READ;
        idx_r <= 4'h0;
        addr_r <= lb.ea;
      end else if (st_r == LDR_READ && lb.mem_ack) begin
        wr_r <= 1'b1;
        data_r <= lb.mem_rdata;
        if (last) begin
          st_r <= LDR_IDLE;
          done_r <= 1'b1;
        end else begin
          idx_r <= idx_r + 4'h1;
          addr_r <= addr_r + `ESL_WORD_STEP;
        end
      end
    end
  end
  // index of the word carried on data, delayed to match
  logic [3:0] widx_r;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) widx_r <= 4'h0;
    else if (ce_i && lb.mem_ack) widx_r <= idx_r;
  end
  assign lb.busy = (st_r == LDR_READ) || done_r;
  assign lb.done = done_r;
  assign lb.mem_req = (st_r == LDR_READ);
  assign lb.mem_addr = addr_r;
  assign lb.wr = wr_r;
  assign lb.idx = widx_r;
  assign lb.data = data_r;
endmodule : esl_lsb_loader
`default_nettype wire

// [logic/esl_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "esl_regs.svh"
module esl_top (
  input wire logic core_clk_i,               // core clock
  input wire logic srst_i,                   // sync reset
  input wire logic ce_i,                     // clock enable
  input wire logic instr_valid_i,            // decoder presents instruction
  input wire logic [4:0] opcode_i,           // operation code
  input wire logic [4:0] func_i,             // function field
  input wire esl_pkg::esl_word_t iar_i,      // address of instruction
  input wire logic exec_i,                   // execution advancing
  input wire logic spec_chk_i,               // misaligned operand
  input wire logic bad_addr_i,               // beyond installed storage
  input wire logic priv_op_i,                // privileged instruction
  input wire logic stack_err_i,              // stack exception
  input wire logic par_err_i,                // storage read parity
  input wire logic ctrl_err_i,               // control malfunction
  input wire logic io_hw_err_i,              // i/o interface hw error
  input wire logic io_seq_valid_i,           // interface sequence seen
  input wire logic io_seq_nondpc_i,          // it was interrupt/cycle steal
  input wire logic auto_ipl_i,               // automatic program load
  input wire logic pwr_warn_i,               // power/thermal warning
  input wire logic cpsr_req_i,               // copy-status request
  input wire esl_pkg::esl_word_t cpsr_ea_i,  // copy-status target
  input wire logic set_level_block_op_req_i,               // set-level-block request
  input wire esl_pkg::esl_word_t set_level_block_op_ea_i,  // block address
  input wire esl_pkg::esl_lvl_t set_level_block_op_lvl_i,  // selected level
  input wire logic lex_req_i,                // level exit
  input wire logic [3:0] prio_req_i,         // pending level requests
  input wire logic prio_enter_i,             // priority interrupt taken
  input wire esl_pkg::esl_lvl_t prio_lvl_i,  // level entered
  output logic mem_req_o,                    // storage request
  output logic mem_we_o,                     // storage write
  output esl_pkg::esl_word_t mem_addr_o,     // storage address
  output esl_pkg::esl_word_t mem_wdata_o,    // storage write data
  input wire logic mem_ack_i,                // storage done
  input wire esl_pkg::esl_word_t mem_rdata_i,// storage read data
  output esl_pkg::esl_word_t processor_status_word_o, // status word
  output logic class_mchk_o,                 // machine check pulse
  output logic class_pchk_o,                 // program check pulse
  output logic class_trap_o,                 // soft trap pulse
  output logic class_pwr_o,                  // power/thermal pulse
  output logic io_reset_o,                   // channel/device reset pulse
  output esl_pkg::esl_word_t trap_iar_o,     // saved excepting address
  output logic lsb_wr_o,                     // hardware block write
  output esl_pkg::esl_lvl_t lsb_lvl_o,       // block level
  output logic [3:0] lsb_idx_o,              // word index in block
  output esl_pkg::esl_word_t lsb_data_o,     // word value
  output esl_pkg::esl_lvl_t cur_lvl_o,       // current level
  output logic lvl_active_o,                 // some level active
  output logic [3:0] pending_o,              // pending levels
  output logic supervisor_o,                 // active supervisor bit
  output logic summary_mask_o,               // active summary mask
  output logic busy_o                        // copy or load running
);
  import esl_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lowest index wins: level 0 is the highest priority
  function automatic logic [2:0] esl_first(input logic [3:0] v);
    logic [2:0] r;
    r = 3'b100;
    if (v[3]) r = 3'b011;
    if (v[2]) r = 3'b010;
    if (v[1]) r = 3'b001;
    if (v[0]) r = 3'b000;
    return r;
  endfunction : esl_first

  // ----------------------------------------
  // state
  // ----------------------------------------
  esl_st_t st_r;
  esl_st_t st_nxt;
  esl_word_t psw_r;
  esl_word_t psw_nxt;
  esl_word_t snap_r;
  esl_word_t cp_ea_r;
  esl_lvl_t sel_r;
  esl_lvl_t cur_r;
  esl_lvl_t cur_nxt;
  logic act_r;
  logic act_nxt;
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  esl_word_t lsr_r [4];
  logic pwr_taken_r;
  logic mchk_r;
  logic pchk_r;
  logic trap_r;
  logic pwr_r;
  logic iorst_r;
  esl_word_t trap_iar_r;

  esl_ldr_if lb ();

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  wire esl_word_t act_lsr = lsr_r[cur_r];
  wire sup = act_lsr[`ESL_LSR_SUP];
  wire sum_en = act_lsr[`ESL_LSR_SUM];
  logic illegal;
  logic reserved;

  esl_opdecode u_dec (
    .opcode_i (opcode_i),
    .func_i (func_i),
    .sup_i (sup),
    .illegal_o (illegal),
    .reserved_o (reserved)
  );

  esl_lsb_loader u_ldr (
    .core_clk_i (core_clk_i),
    .srst_i (srst_i),
    .ce_i (ce_i),
    .lb (lb.ldr)
  );

  // ----------------------------------------
  // event recording
  // ----------------------------------------
  wire ev_ill = instr_valid_i && illegal;
  wire ev_res = instr_valid_i && reserved && !illegal;
  wire ev_priv = priv_op_i && !sup;
  wire ev_ctrl = ctrl_err_i || (exec_i && !act_r);
  wire ev_io = io_hw_err_i;
  // each event sets its own bit, illegal and reserved share INVFN, control fault and execution with no level active share CTRL; hardware alone drives these inputs
  wire esl_word_t set_vec = ({15'h0000, pwr_warn_i} << `ESL_B_PWR)
                          | ({15'h0000, auto_ipl_i} << `ESL_B_AIPL)
                          | ({15'h0000, ev_io} << `ESL_B_IOCHK)
                          | ({15'h0000, ev_ctrl} << `ESL_B_CTRL)
                          | ({15'h0000, par_err_i} << `ESL_B_PARITY)
                          | ({15'h0000, stack_err_i} << `ESL_B_STACK)
                          | ({15'h0000, ev_ill || ev_res} << `ESL_B_INVFN)
                          | ({15'h0000, ev_priv} << `ESL_B_PRIV)
                          | ({15'h0000, bad_addr_i} << `ESL_B_BADADR)
                          | ({15'h0000, spec_chk_i} << `ESL_B_SPEC);

  // class selection per status bit
  wire ev_mchk = par_err_i || ev_ctrl || ev_io;
  wire ev_pchk = spec_chk_i || bad_addr_i || ev_priv || ev_ill;
  wire ev_trap = stack_err_i || ev_res;
  wire ev_iorst = ev_ctrl || ev_io;

  // copy completes on the storage handshake of the write
  wire cp_done = (st_r == ST_COPY) && mem_ack_i;
  // clear only what was stored, so a fresh event in that cycle survives
  wire esl_word_t cleared = cp_done ? (psw_r & ~snap_r) : psw_r;
  wire seq_nxt = io_seq_valid_i ? io_seq_nondpc_i : psw_r[`ESL_B_SEQ];

  always_comb begin
    psw_nxt = (cleared | set_vec) & `ESL_PSW_USED;
    psw_nxt[`ESL_B_SEQ] = seq_nxt;
  end

  // ----------------------------------------
  // status word and class pulses
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      psw_r <= `ESL_PSW_RST;
    end else if (ce_i) begin
      psw_r <= psw_nxt;
    end
  end

  // power class waits for the summary mask; taken once per recording
  wire pwr_fire = psw_r[`ESL_B_PWR] && !pwr_taken_r && sum_en;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mchk_r <= 1'b0;
      pchk_r <= 1'b0;
      trap_r <= 1'b0;
      pwr_r <= 1'b0;
      iorst_r <= 1'b0;
      pwr_taken_r <= 1'b0;
    end else if (ce_i) begin
      mchk_r <= ev_mchk;
      pchk_r <= ev_pchk;
      trap_r <= ev_trap;
      pwr_r <= pwr_fire;
      iorst_r <= ev_iorst;
      pwr_taken_r <= psw_nxt[`ESL_B_PWR] && (pwr_taken_r || pwr_fire);
    end
  end

  // excepting address kept for the stored block; processor untouched
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trap_iar_r <= 16'h0000;
    end else if (ce_i && ev_trap) begin
      trap_iar_r <= iar_i;
    end
  end

  // ----------------------------------------
  // copy / load sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (cpsr_req_i) begin
          st_nxt = ST_COPY;
        end else if (set_level_block_op_req_i) begin
          st_nxt = ST_LOAD;
        end
      end
      ST_COPY: begin
        if (mem_ack_i) st_nxt = ST_IDLE;
      end
      ST_LOAD: begin
        if (lb.done) st_nxt = ST_SWITCH;
      end
      ST_SWITCH: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  wire go_copy = (st_r == ST_IDLE) && cpsr_req_i;
  wire go_load = (st_r == ST_IDLE) && !cpsr_req_i && set_level_block_op_req_i;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= ST_IDLE;
      snap_r <= 16'h0000;
      cp_ea_r <= 16'h0000;
      sel_r <= 2'b00;
    end else if (ce_i) begin
      st_r <= st_nxt;
      if (go_copy) begin
        snap_r <= psw_r;
        cp_ea_r <= cpsr_ea_i;
      end
      if (go_load) sel_r <= set_level_block_op_lvl_i;
    end
  end

  // loader hook-up; it owns storage only while loading
  assign lb.start = go_load;
  assign lb.ea = set_level_block_op_ea_i;
  assign lb.mem_ack = mem_ack_i && (st_r == ST_LOAD);
  assign lb.mem_rdata = mem_rdata_i;

  // storage port: copy writes one word, load reads the block
  wire copy_on = (st_r == ST_COPY);
  assign mem_req_o = copy_on || lb.mem_req;
  assign mem_we_o = copy_on;
  assign mem_addr_o = copy_on ? cp_ea_r : lb.mem_addr;
  assign mem_wdata_o = snap_r;

  // ----------------------------------------
  // hardware level blocks (status words kept here)
  // ----------------------------------------
  wire lsr_wr = lb.wr && (lb.idx == `ESL_LSB_IDX_LSR);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 4; i++) lsr_r[i] <= `ESL_LSR_RST;
    end else if (ce_i && lsr_wr) begin
      lsr_r[sel_r] <= lb.data;
    end
  end

  // ----------------------------------------
  // level switching
  // ----------------------------------------
  // masks take no part here, priority and the in-process bit decide
  wire inproc = lsr_r[sel_r][`ESL_LSR_INPROC];
  wire [2:0] pend_top = esl_first(pend_r);
  wire [2:0] req_top = esl_first(prio_req_i);
  wire lex_ok = lex_req_i && act_r && (st_r == ST_IDLE);

  always_comb begin
    cur_nxt = cur_r;
    act_nxt = act_r;
    pend_nxt = pend_r;
    if (prio_enter_i) begin
      if (act_r) pend_nxt[cur_r] = 1'b1;
      cur_nxt = prio_lvl_i;
      act_nxt = 1'b1;
      pend_nxt[prio_lvl_i] = 1'b0;
    end else if (st_r == ST_SWITCH && inproc) begin
      if (!act_r || sel_r == cur_r) begin
        cur_nxt = sel_r;
        act_nxt = 1'b1;
      end else if (sel_r < cur_r) begin
        pend_nxt[cur_r] = 1'b1;
        cur_nxt = sel_r;
      end else begin
        pend_nxt[sel_r] = 1'b1;
      end
    end else if (lex_ok) begin
      act_nxt = 1'b0;
      // a pending level resumes only if nothing higher is asking
      if (!pend_top[2] && !(req_top < pend_top)) begin
        cur_nxt = pend_top[1:0];
        act_nxt = 1'b1;
        pend_nxt[pend_top[1:0]] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cur_r <= 2'b00;
      act_r <= 1'b1;
      pend_r <= 4'h0;
    end else if (ce_i) begin
      cur_r <= cur_nxt;
      act_r <= act_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign processor_status_word_o = psw_r;
  assign class_mchk_o = mchk_r;
  assign class_pchk_o = pchk_r;
  assign class_trap_o = trap_r;
  assign class_pwr_o = pwr_r;
  assign io_reset_o = iorst_r;
  assign trap_iar_o = trap_iar_r;
  assign lsb_wr_o = lb.wr;
  assign lsb_lvl_o = sel_r;
  assign lsb_idx_o = lb.idx;
  assign lsb_data_o = lb.data;
  assign cur_lvl_o = cur_r;
  assign lvl_active_o = act_r;
  assign pending_o = pend_r;
  assign supervisor_o = sup;
  assign summary_mask_o = sum_en;
  assign busy_o = (st_r != ST_IDLE);
endmodule : esl_top
`default_nettype wire

// [bench/esl_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// storage answering requests
// ----------------------------
module esl_mem_model (
  input wire logic clk_i, // core clock
  input wire logic req_i, // storage request
  input wire logic [15:0] addr_i, // storage address
  input wire logic [15:0] lsr_addr_i, // where the status word sits
  input wire logic [15:0] lsr_i, // status word to return there
  output logic ack_o, // one-cycle answer
  output logic [15:0] rdata_o // read data, valid with answer
);
  int wait_q = 0;
  logic ack_r = 1'b0;
  logic [15:0] rd_r = 16'h0000;
  assign ack_o = ack_r;
  assign rdata_o = rd_r;
  // random wait gives prompt and slow answers; data toggles when idle
  always @(posedge clk_i) begin
    ack_r <= 1'b0;
    rd_r <= ~rd_r;
    if (req_i && !ack_r) begin
      if (wait_q == 0) begin
        ack_r <= 1'b1;
        rd_r <= (addr_i == lsr_addr_i) ? lsr_i : ~addr_i;
        wait_q = $urandom_range(3);
      end else begin
        wait_q--;
      end
    end
  end
endmodule : esl_mem_model
`default_nettype wire

// [bench/esl_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "esl_regs.svh"
// ---------------------
// status word checker
// ---------------------
module esl_top_asserts (
  input wire logic core_clk_i, // clock
  input wire logic srst_i, // reset
  input wire logic ce_i, // enable
  input wire logic spec_chk_i, // misaligned
  input wire logic priv_op_i, // privileged op
  input wire logic stack_err_i, // stack fault
  input wire logic par_err_i, // parity
  input wire logic ctrl_err_i, // control fault
  input wire logic io_hw_err_i, // i/o fault
  input wire logic exec_i, // executing
  input wire logic io_seq_valid_i, // sequence seen
  input wire logic io_seq_nondpc_i, // sequence kind
  input wire esl_pkg::esl_word_t iar_i, // instr address
  input wire esl_pkg::esl_word_t processor_status_word_o, // status
  input wire esl_pkg::esl_word_t trap_iar_o, // saved address
  input wire logic class_mchk_o, // machine check
  input wire logic class_pchk_o, // program check
  input wire logic class_trap_o, // soft trap
  input wire logic class_pwr_o, // power class
  input wire logic io_reset_o, // channel reset
  input wire logic lvl_active_o, // level active
  input wire logic supervisor_o, // supervisor
  input wire logic summary_mask_o // summary mask
);
  import esl_pkg::*;
  esl_word_t processor_status_word;
  logic hw_chk;
  // control and i/o faults share one reset path, parity must not reach it
  assign processor_status_word = processor_status_word_o;
  assign hw_chk = ce_i && (ctrl_err_i || io_hw_err_i || (exec_i && !lvl_active_o));
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_spec_bit_set: assert property (ce_i && spec_chk_i |=> processor_status_word[15] && class_pchk_o)
    else $error("alignment fault not recorded");
  a_priv_bit_set: assert property (ce_i && priv_op_i && !supervisor_o |=> processor_status_word[13])
    else $error("privilege fault not recorded");
  a_stack_trap_iar: assert property (ce_i && stack_err_i |=> processor_status_word[9] && class_trap_o && trap_iar_o == $past(iar_i))
    else $error("stack trap wrong");
  a_parity_mchk: assert property (ce_i && par_err_i |=> processor_status_word[7] && class_mchk_o)
    else $error("parity not recorded");
  a_io_check_reset: assert property (ce_i && io_hw_err_i |=> processor_status_word[4] && class_mchk_o && io_reset_o)
    else $error("i/o check without reset");
  a_ctrl_check_reset: assert property (ce_i && (ctrl_err_i || exec_i && !lvl_active_o) |=> processor_status_word[5] && io_reset_o)
    else $error("control check without reset");
  a_reset_has_cause: assert property (io_reset_o |-> $past(hw_chk))
    else $error("channel reset without cause");
  a_unused_zero: assert property ((processor_status_word & ~`ESL_PSW_USED) == 16'h0000)
    else $error("unused status bit set");
  a_seq_tracks: assert property (ce_i && io_seq_valid_i |=> processor_status_word[3] == $past(io_seq_nondpc_i))
    else $error("sequence bit wrong");
  a_pwr_masked: assert property (class_pwr_o |-> $past(summary_mask_o && processor_status_word[0]))
    else $error("power class while masked");
  c_trap: cover property (class_trap_o);
  c_io_reset: cover property (io_reset_o);
  c_pwr: cover property (class_pwr_o);
endmodule : esl_top_asserts
bind esl_top esl_top_asserts u_chk (.*);
`default_nettype wire

// [bench/tb_error_status_and_level_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_error_status_and_level_switch;
  import esl_pkg::*;
  // ------------------
  // stimulus and dut
  // ------------------
  logic core_clk_i, srst_i = 1'b1, ce_i = 1'b1, instr_valid_i = 1'b0, exec_i = 1'b0;
  logic io_seq_valid_i = 1'b0, io_seq_nondpc_i = 1'b0, cpsr_req_i = 1'b0, set_level_block_op_req_i = 1'b0;
  logic lex_req_i = 1'b0, prio_enter_i = 1'b0, mem_ack_i, seq = 1'b0;
  logic [4:0] opcode_i = 5'h00, func_i = 5'h00;
  logic [8:0] ev = 9'h000;
  logic [3:0] prio_req_i = 4'h0, pending_o, lsb_idx_o;
  esl_lvl_t set_level_block_op_lvl_i = 2'h0, prio_lvl_i = 2'h0, lsb_lvl_o, cur_lvl_o;
  esl_word_t iar_i = 16'h0000, cpsr_ea_i = 16'h0000, set_level_block_op_ea_i = 16'h0000, lsr_w = 16'h0000;
  esl_word_t mem_addr_o, mem_wdata_o, mem_rdata_i, processor_status_word_o, trap_iar_o;
  esl_word_t lsb_data_o, xp;
  logic mem_req_o, mem_we_o, class_mchk_o, class_pchk_o, class_trap_o, class_pwr_o, io_reset_o;
  logic lsb_wr_o, lvl_active_o, supervisor_o, summary_mask_o, busy_o;
  wire logic spec_chk_i, bad_addr_i, priv_op_i, stack_err_i, par_err_i, ctrl_err_i;
  wire logic io_hw_err_i, auto_ipl_i, pwr_warn_i;
  int failures = 0, checked = 0;
  int pos[9] = '{15, 14, 13, 9, 7, 5, 4, 2, 0};
  logic [4:0] opt[7] = '{5'h07, 5'h16, 5'h1B, 5'h04, 5'h08, 5'h08, 5'h08};
  // one vector drives all single-cycle fault inputs
  assign {pwr_warn_i, auto_ipl_i, io_hw_err_i, ctrl_err_i, par_err_i} = ev[8:4];
  assign {stack_err_i, priv_op_i, bad_addr_i, spec_chk_i} = ev[3:0];
  esl_top DUT (.*);
  esl_mem_model u_mem (.clk_i(core_clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
    .lsr_addr_i(set_level_block_op_ea_i + 16'h0004), .lsr_i(lsr_w), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ----------------------
  // expectations, tasks
  // ----------------------
  function automatic esl_word_t pbit(input logic [8:0] e, input logic s);
    esl_word_t r = 16'h0000;
    for (int i = 0; i < 9; i++) if (e[i] && !(i == 2 && s)) r[pos[i]] = 1'b1;
    return r;
  endfunction : pbit
  // order: machine, program, trap, power, channel reset
  function automatic logic [4:0] cls(input logic [8:0] e, input logic s, input logic m);
    return {e[4] | e[5] | e[6], e[0] | e[1] | (e[2] & !s), e[3], e[8] & m, e[5] | e[6]};
  endfunction : cls
  task complete_run;
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task tmo;
    failures++;
    complete_run;
  endtask : tmo
  task tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick
  task chk(input esl_word_t seen, input esl_word_t exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task lv(input esl_word_t x);
    chk({7'h00, cur_lvl_o, lvl_active_o, supervisor_o, summary_mask_o, pending_o}, x);
  endtask : lv
  // copy and clear; request dropped once storage traffic shows it was taken
  task cp(input esl_word_t snap);
    int n;
    cpsr_ea_i = 16'($urandom);
    cpsr_req_i = 1'b1;
    for (n = 0; n < 20 && mem_req_o !== 1'b1; n++) tick;
    if (n == 20) tmo;
    cpsr_req_i = 1'b0;
    chk({15'h0000, mem_we_o}, 16'h0001);
    chk(mem_addr_o, cpsr_ea_i);
    chk(mem_wdata_o, snap);
    for (n = 0; n < 50 && busy_o !== 1'b0; n++) tick;
    if (n == 50) tmo;
    chk(processor_status_word_o, {12'h000, seq, 3'h0});
  endtask : cp
  // power class comes one cycle later, so two cycles are merged
  task shot(input logic [4:0] xc, input esl_word_t xb);
    logic [4:0] cv;
    tick;
    ev = 9'h000;
    instr_valid_i = 1'b0;
    exec_i = 1'b0;
    cv = {class_mchk_o, class_pchk_o, class_trap_o, class_pwr_o, io_reset_o};
    tick;
    cv |= {class_mchk_o, class_pchk_o, class_trap_o, class_pwr_o, io_reset_o};
    chk({11'h000, cv}, {11'h000, xc});
    cp(xb | {12'h000, seq, 3'h0});
  endtask : shot
  task evloop(input logic s, input logic m);
    for (int i = 0; i < 9; i++) begin
      iar_i = 16'($urandom);
      ev = 9'h001 << i;
      shot(cls(ev, s, m), pbit(ev, s));
      if (i == 3) chk(trap_iar_o, iar_i);
    end
  endtask : evloop
  task set_level_block_op(input esl_lvl_t lvl, input esl_word_t level_status_register);
    int n;
    int k;
    set_level_block_op_ea_i = 16'($urandom) & 16'hFF00;
    set_level_block_op_lvl_i = lvl;
    lsr_w = level_status_register;
    set_level_block_op_req_i = 1'b1;
    k = 0;
    tick;
    set_level_block_op_req_i = 1'b0;
    for (n = 0; n < 300 && (busy_o === 1'b1 || lsb_wr_o === 1'b1); n++) begin
      if (lsb_wr_o === 1'b1) begin
        chk({12'h000, lsb_idx_o}, k[15:0]);
        chk(lsb_data_o, k == 2 ? level_status_register : ~(set_level_block_op_ea_i + 16'(2 * k)));
        chk({14'h0000, lsb_lvl_o}, {14'h0000, lvl});
        k++;
      end
      tick;
    end
    if (n == 300) tmo;
    chk(k[15:0], 16'h000B);
    tick;
  endtask : set_level_block_op
  task lexit;
    lex_req_i = 1'b1;
    tick;
    lex_req_i = 1'b0;
    tick;
  endtask : lexit
  // -----------
  // sequence
  // -----------
  initial begin
    void'($urandom(32'heabaa70a));
    repeat (6) @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    chk(processor_status_word_o, 16'h0000);
    lv(16'h0050);
    ce_i = 1'b0;
    ev = 9'h001;
    tick;
    chk(processor_status_word_o, 16'h0000);
    ce_i = 1'b1;
    ev = 9'h000;
    evloop(1'b0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      opcode_i = opt[i];
      func_i = i < 4 ? 5'($urandom) : 5'(i - 3);
      instr_valid_i = 1'b1;
      shot(i == 3 ? 5'h04 : 5'h08, 16'h0800);
    end
    for (int r = 0; r < 5; r++) begin
      xp = 16'h0000;
      for (int j = 0; j < 6; j++) begin
        ev = 9'($urandom);
        io_seq_valid_i = 1'($urandom);
        io_seq_nondpc_i = 1'($urandom);
        xp |= pbit(ev, 1'b0);
        if (io_seq_valid_i) seq = io_seq_nondpc_i;
        tick;
      end
      ev = 9'h000;
      io_seq_valid_i = 1'b0;
      tick;
      chk(processor_status_word_o, xp | {12'h000, seq, 3'h0});
      cp(xp | {12'h000, seq, 3'h0});
    end
    set_level_block_op(2'h2, 16'h00C0);
    lv(16'h0054);
    lexit;
    lv(16'h0160);
    set_level_block_op(2'h2, 16'h0050);
    lv(16'h0150);
    set_level_block_op(2'h1, 16'h00C0);
    lv(16'h00E4);
    set_level_block_op(2'h0, 16'h0008);
    lv(16'h00E4);
    evloop(1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      opcode_i = 5'h0B;
      func_i = i == 0 ? 5'h03 : 5'h0B;
      instr_valid_i = 1'b1;
      shot(5'h04, 16'h0800);
    end
    lexit;
    lv(16'h0150);
    prio_lvl_i = 2'h1;
    prio_enter_i = 1'b1;
    tick;
    prio_enter_i = 1'b0;
    lv(16'h00E4);
    prio_req_i = 4'h1;
    lexit;
    lv(16'h00A4);
    chk({15'h0000, lvl_active_o}, 16'h0000);
    exec_i = 1'b1;
    shot(5'h11, 16'h0020);
    complete_run;
  end
endmodule : tb_error_status_and_level_switch
`default_nettype wire
